// *** dccs_partner.sv ***
// partner: remote serial side seen as receiver and transmitter events
`timescale 1ns/1ps
`default_nettype none

module dccs_partner
  import dccs_pkg::*;
(
  input  wire logic      clk_i,
  output var dccs_rx_ev_t rx_ev_o,
  output var dccs_tx_ev_t tx_ev_o
);
  initial begin
    rx_ev_o = '0;
    tx_ev_o = '0;
  end

  // one-cycle pulse after gap idle cycles
  task automatic send(input dccs_rx_ev_t r, input dccs_tx_ev_t t,
                      input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    rx_ev_o <= r;
    tx_ev_o <= t;
    @(posedge clk_i);
    rx_ev_o <= '0;
    tx_ev_o <= '0;
    #1;
  endtask : send
endmodule : dccs_partner

`default_nettype wire

// *** dccs_pkg.sv ***
// package: shared types and constants for the channel command/status block
package dccs_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFS_CHA_CMD_STS = 4'h0;
  localparam logic [3:0]  OFS_CHB_CMD_STS = 4'h1;
  localparam logic [3:0]  OFS_CHB_CLK_SEL = 4'h2;
  localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h3;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_RX_EN_BIT   = 0;
  localparam int CMD_RX_DIS_BIT  = 1;
  localparam int CMD_TX_EN_BIT   = 2;
  localparam int CMD_TX_DIS_BIT  = 3;
  localparam int CMD_MISC_LSB    = 4;
  localparam int IRQ_BRKCHG_A    = 2;
  localparam int IRQ_BRKCHG_B    = 6;
  localparam int CSEL_TX_LSB     = 0;
  localparam int CSEL_RX_LSB     = 4;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  CLK_SEL_RST    = 8'h00;
  localparam logic [7:0]  RDATA_RST      = 8'h00;
  localparam int          FIFO_DEPTH_DEF = 3;
  localparam int          FCNT_W         = 2;
  localparam logic [1:0]  PAR_MULTIDROP  = 2'h3;
  localparam int unsigned BRG_REF_HZ     = 3686400;
  localparam int unsigned BRG_OVERSAMPLE = 16;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MISC_NONE, MISC_PTR_RST, MISC_RX_RST, MISC_TX_RST,
    MISC_ERR_RST, MISC_BRKCHG_RST, MISC_BRK_START, MISC_BRK_STOP
  } dccs_misc_t;

  localparam logic [3:0] CSEL_TIMER  = 4'hd;
  localparam logic [3:0] CSEL_PIN16  = 4'he;
  localparam logic [3:0] CSEL_PIN1   = 4'hf;

  typedef enum logic [1:0] {SRC_BRG, SRC_TIMER, SRC_PIN} dccs_src_t;
  typedef enum logic [1:0] {BRK_IDLE, BRK_PEND, BRK_ON, BRK_MARK}
    dccs_brk_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic char_in;
    logic brk;
    logic fe;
    logic pe;
    logic ad_bit;
    logic brk_end;
    logic rhr_read;
  } dccs_rx_ev_t;

  typedef struct packed {
    logic thr_load;
    logic shift_load;
    logic stop_done;
    logic bit_tick;
  } dccs_tx_ev_t;

  typedef struct packed {
    logic rx_active;
    logic rx_hunt;
    logic rx_flush;
    logic tx_en;
    logic tx_reset;
    logic mr_ptr_rst;
    logic break_out;
    logic mark_hold;
  } dccs_ctl_t;

  typedef struct packed {
    dccs_src_t   src;
    logic        pin_six;
    logic        is_1x;
    logic [12:0] brg_div;
  } dccs_clksel_t;

endpackage : dccs_pkg

// *** dccs_top.sv ***
// module: command decode, status flags and channel B clock select
// Function
// R01: chan B rx code 1110 picks a pin at 16X, 1111 a pin at 1X.
// R02: chan B tx codes 1110/1111 take input pin five at 16X or 1X.
// R03: every command in one command write acts; software avoids conflicts.
// R04: misc code 000 does nothing; 001 returns mode pointer to first.
// R05: code 010 resets receiver and flushes FIFO; 011 resets transmitter.
// R06: code 100 clears break, parity, framing and overrun status bits.
// R07: code 101 clears the channel change-in-break interrupt status bit.
// R08: code 110 starts break after queued characters; needs enabled tx.
// R09: code 111 ends break, then one marking bit before next character.
// R10: tx disable clears ready and empty; enable starts tx, sets ready.
// R11: rx disable stops at once, keeps status; multidrop keeps receiving.
// R12: rx enable starts receiver and start-bit hunt unless multidrop.
// R13: channel B command and status mirror channel A exactly.
// R14: break flag on all-zero frame; start and end set break change.
// R15: mid-character break counts only if it lasts a full character.
// R16: framing flag marks a character with a missing first stop bit.
// R17: parity flag per character; in multidrop holds address/data bit.
// R18: overrun on arrival with FIFO full and one waiting; waiting lost.
// R19: tx empty sets after last stop with holding empty; load clears.
// R20: tx ready clears on load, sets on transfer and first enable.
// R21: FIFO full sets when three entries fill; read keeps it if waiting.
// R22: rx ready sets on FIFO entry, clears on read leaving FIFO empty.
// R23: clock codes map to rates of a 3.6864 MHz reference; 1101 timer.
// R24: parity mode field 11 selects multidrop mode.
// R25: command bit 7 is ignored on writes.
`timescale 1ns/1ps
`default_nettype none

module dccs_top
  import dccs_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic              CLK_I,
  input  wire logic              RSTN_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [7:0]        RDATA_O,
  input  wire logic              BAUD_SET_I,
  input  wire logic [1:0]        PAR_MODE_A_I,
  input  wire logic [1:0]        PAR_MODE_B_I,
  input  wire dccs_rx_ev_t       RX_EV_A_I,
  input  wire dccs_rx_ev_t       RX_EV_B_I,
  input  wire dccs_tx_ev_t       TX_EV_A_I,
  input  wire dccs_tx_ev_t       TX_EV_B_I,
  output dccs_ctl_t              CTL_A_O,
  output dccs_ctl_t              CTL_B_O,
  output dccs_clksel_t           CLK_RX_B_O,
  output dccs_clksel_t           CLK_TX_B_O
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 3) begin : g_bad_depth
    $error("FIFO_DEPTH must lie between 1 and 3");
  end

  localparam logic [FCNT_W-1:0] FULL_CNT = FCNT_W'(FIFO_DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dccs_ctl_t         ctl;
    logic              rx_en;
    logic              brk;
    logic              fe;
    logic              pe;
    logic              ovr;
    logic              tx_underrun_flag;
    logic              tx_holding_free_flag;
    logic              rx_fifo_full_flag;
    logic              rx_char_avail_flag;
    logic [FCNT_W-1:0] fcnt;
    logic              wait_full;
    logic [2:0]        wait_err;
    logic              thr_full;
    logic              busy;
    logic              brkchg;
    dccs_brk_t         bstate;
  } dccs_chan_t;

  typedef struct packed {
    dccs_chan_t [1:0] ch;
    logic [7:0]       csel;
    dccs_clksel_t     rx_b;
    dccs_clksel_t     tx_b;
    logic [7:0]       rdata;
  } dccs_state_t;

  dccs_state_t state_q;
  dccs_state_t state_d;
  logic        rst_meta_q;
  logic        rst_sync_q;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // rate in tenths of a baud so that 134.5 stays exact
  function automatic int unsigned rate_tenths(input logic [3:0] code,
                                              input logic       set2);
    int unsigned r;
    r = 0;
    case (code)
      4'h0:    r = set2 ? 750    : 500;
      4'h1:    r = 1100;
      4'h2:    r = 1345;
      4'h3:    r = set2 ? 1500   : 2000;
      4'h4:    r = 3000;
      4'h5:    r = 6000;
      4'h6:    r = 12000;
      4'h7:    r = set2 ? 20000  : 10500;
      4'h8:    r = 24000;
      4'h9:    r = 48000;
      4'ha:    r = set2 ? 18000  : 72000;
      4'hb:    r = 96000;
      4'hc:    r = set2 ? 192000 : 384000;
      default: r = 0;
    endcase
    return r;
  endfunction : rate_tenths

  function automatic dccs_clksel_t clk_sel(input logic [3:0] code,
                                           input logic       set2,
                                           input logic       rx_side);
    dccs_clksel_t s;
    int unsigned  r;
    s = '0;
    r = rate_tenths(code, set2);
    s.src = SRC_BRG;
    s.is_1x = (code == CSEL_PIN1); // R01 R02
    if (code == CSEL_TIMER) begin
      s.src = SRC_TIMER; // R23
    end else if (code == CSEL_PIN16 || code == CSEL_PIN1) begin
      s.src = SRC_PIN;
      // rx 1110 follows the rate set, rx 1111 always uses pin six
      s.pin_six = rx_side && (set2 || code == CSEL_PIN1); // R01 R02
    end else if (r != 0) begin
      s.brg_div = 13'((BRG_REF_HZ * 10) / (BRG_OVERSAMPLE * r)); // R23
    end
    return s;
  endfunction : clk_sel

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    dccs_chan_t   c;
    dccs_rx_ev_t  rx;
    dccs_tx_ev_t  tx;
    dccs_misc_t   misc;
    logic         cmd_wr;
    logic         mdrop;
    logic         was_on;
    logic         pop;
    logic         push;
    c      = '0;
    rx     = '0;
    tx     = '0;
    misc   = MISC_NONE;
    cmd_wr = 1'b0;
    mdrop  = 1'b0;
    was_on = 1'b0;
    pop    = 1'b0;
    push   = 1'b0;
    state_d = state_q;

    for (int i = 0; i < 2; i++) begin
      c  = state_q.ch[i];
      rx = (i == 0) ? RX_EV_A_I : RX_EV_B_I;
      tx = (i == 0) ? TX_EV_A_I : TX_EV_B_I;
      mdrop = ((i == 0) ? PAR_MODE_A_I : PAR_MODE_B_I)
              == PAR_MULTIDROP; // R24
      // same decode for both channels
      cmd_wr = WR_I && ADDR_I == ((i == 0) ? OFS_CHA_CMD_STS
                                           : OFS_CHB_CMD_STS); // R13
      // bit 7 never reaches the decode
      misc = dccs_misc_t'(WDATA_I[CMD_MISC_LSB +: 3]); // R25
      if (!cmd_wr) begin
        misc = MISC_NONE; // R04
      end

      c.ctl.rx_hunt    = 1'b0;
      c.ctl.rx_flush   = 1'b0;
      c.ctl.tx_reset   = 1'b0;
      c.ctl.mr_ptr_rst = (misc == MISC_PTR_RST); // R04

      // receiver enable/disable, all bits of one write act
      if (cmd_wr && WDATA_I[CMD_RX_DIS_BIT]) begin
        c.rx_en = 1'b0; // R11 R03
      end
      if (cmd_wr && WDATA_I[CMD_RX_EN_BIT]) begin
        c.rx_en = 1'b1; // R12 R03
        c.ctl.rx_hunt = !mdrop; // R12
      end

      // transmitter enable/disable
      was_on = c.ctl.tx_en;
      if (cmd_wr && WDATA_I[CMD_TX_DIS_BIT]) begin
        // queued characters still drain outside
        c.ctl.tx_en = 1'b0; // R10
        c.tx_holding_free_flag = 1'b0; // R10 R20
        c.tx_underrun_flag = 1'b0; // R10 R19
      end
      if (cmd_wr && WDATA_I[CMD_TX_EN_BIT]) begin
        c.ctl.tx_en = 1'b1; // R10
        if (!was_on) begin
          c.tx_holding_free_flag = 1'b1; // R20
        end
      end

      // transmitter flags
      if (tx.thr_load) begin
        c.thr_full = 1'b1;
        c.tx_holding_free_flag = 1'b0; // R20
        c.tx_underrun_flag = 1'b0; // R19
      end
      if (tx.shift_load) begin
        c.thr_full = 1'b0;
        c.busy = 1'b1;
        c.tx_holding_free_flag = c.ctl.tx_en; // R20
      end
      if (tx.stop_done) begin
        c.busy = tx.shift_load;
        if (!c.thr_full && c.ctl.tx_en) begin
          c.tx_underrun_flag = 1'b1; // R19
        end
      end

      // break sequencer, stepped on transmit bit times
      case (c.bstate)
        BRK_IDLE: begin
          if (misc == MISC_BRK_START && c.ctl.tx_en) begin
            c.bstate = BRK_PEND; // R08
          end
        end
        BRK_PEND: begin
          if (misc == MISC_BRK_STOP) begin
            c.bstate = BRK_IDLE; // R09
          end else if (tx.bit_tick && !c.busy && !c.thr_full) begin
            c.bstate = BRK_ON; // R08
          end
        end
        BRK_ON: begin
          if (misc == MISC_BRK_STOP) begin
            c.bstate = BRK_MARK; // R09
          end
        end
        BRK_MARK: begin
          // a tick ends the line low, the next ends the mark bit
          if (tx.bit_tick && !c.ctl.break_out) begin
            c.bstate = BRK_IDLE; // R09
          end
        end
        default: c.bstate = BRK_IDLE;
      endcase

      // receive FIFO bookkeeping; a read frees the slot first
      c.ctl.rx_active = c.rx_en || mdrop; // R11
      pop  = rx.rhr_read && c.fcnt != '0;
      push = rx.char_in && c.ctl.rx_active;
      if (misc == MISC_ERR_RST) begin
        c.brk = 1'b0; // R06
        c.fe  = 1'b0; // R06
        c.pe  = 1'b0; // R06
        c.ovr = 1'b0; // R06 R18
      end
      if (misc == MISC_BRKCHG_RST) begin
        c.brkchg = 1'b0; // R07
      end
      if (pop) begin
        if (c.wait_full) begin
          // waiting character moves up, FIFO stays full
          c.wait_full = 1'b0; // R21
          {c.brk, c.fe, c.pe} = {c.brk, c.fe, c.pe} | c.wait_err;
        end else begin
          c.fcnt  = c.fcnt - 1'b1;
          c.rx_fifo_full_flag = 1'b0; // R21
          c.rx_char_avail_flag = (c.fcnt != '0); // R22
        end
      end
      if (push) begin
        if (c.fcnt == FULL_CNT && c.wait_full) begin
          c.ovr = 1'b1; // R18
          c.wait_err = {rx.brk, rx.fe, mdrop ? rx.ad_bit : rx.pe}; // R18
        end else if (c.fcnt == FULL_CNT) begin
          c.wait_full = 1'b1; // R21
          c.wait_err = {rx.brk, rx.fe, mdrop ? rx.ad_bit : rx.pe};
        end else begin
          c.fcnt  = c.fcnt + 1'b1;
          c.rx_char_avail_flag = 1'b1; // R22
          c.rx_fifo_full_flag = (c.fcnt == FULL_CNT); // R21
          // receiver flags a break only after a full frame of zeros
          c.brk = c.brk | rx.brk; // R14 R15
          c.fe  = c.fe | rx.fe; // R16
          c.pe  = c.pe | (mdrop ? rx.ad_bit : rx.pe); // R17
        end
        if (rx.brk) begin
          c.brkchg = 1'b1; // R14
        end
      end
      if (rx.brk_end && c.ctl.rx_active) begin
        c.brkchg = 1'b1; // R14
      end

      // resets placed last so they win over this cycle's traffic
      if (misc == MISC_RX_RST) begin
        c.rx_en = 1'b0; // R05
        c.ctl.rx_active = mdrop;
        c.ctl.rx_flush = 1'b1; // R05
        c.fcnt = '0; // R05
        c.wait_full = 1'b0;
        c.wait_err = '0;
        c.rx_char_avail_flag = 1'b0;
        c.rx_fifo_full_flag = 1'b0;
      end
      if (misc == MISC_TX_RST) begin
        c.ctl.tx_en = 1'b0; // R05
        c.ctl.tx_reset = 1'b1; // R05
        c.tx_holding_free_flag = 1'b0;
        c.tx_underrun_flag = 1'b0;
        c.thr_full = 1'b0;
        c.busy = 1'b0;
        c.bstate = BRK_IDLE;
      end

      c.ctl.break_out = (c.bstate == BRK_ON); // R08
      c.ctl.mark_hold = (c.bstate == BRK_MARK) && !state_q.ch[i]
                        .ctl.break_out; // R09
      if (c.bstate == BRK_MARK && state_q.ch[i].ctl.break_out) begin
        // line stays low until the next bit boundary
        c.ctl.break_out = !tx.bit_tick; // R09
        c.ctl.mark_hold = tx.bit_tick;
      end
      state_d.ch[i] = c;
    end

    // channel B clock select
    if (WR_I && ADDR_I == OFS_CHB_CLK_SEL) begin
      state_d.csel = WDATA_I;
    end
    state_d.rx_b = clk_sel(state_q.csel[CSEL_RX_LSB +: 4], BAUD_SET_I,
                           1'b1); // R01
    state_d.tx_b = clk_sel(state_q.csel[CSEL_TX_LSB +: 4], BAUD_SET_I,
                           1'b0); // R02

    // read data stand for exactly one cycle
    state_d.rdata = RDATA_RST;
    if (RD_I) begin
      case (ADDR_I)
        OFS_CHA_CMD_STS, OFS_CHB_CMD_STS: begin
          c = state_q.ch[ADDR_I == OFS_CHB_CMD_STS];
          state_d.rdata = {c.brk, c.fe, c.pe, c.ovr,
                           c.tx_underrun_flag, c.tx_holding_free_flag, c.rx_fifo_full_flag, c.rx_char_avail_flag}; // R13
        end
        OFS_IRQ_STATUS: begin
          state_d.rdata[IRQ_BRKCHG_A] = state_q.ch[0].brkchg;
          state_d.rdata[IRQ_BRKCHG_B] = state_q.ch[1].brkchg;
        end
        default: state_d.rdata = RDATA_RST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q      <= '0;
      state_q.csel <= CLK_SEL_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign RDATA_O    = state_q.rdata;
  assign CTL_A_O    = state_q.ch[0].ctl;
  assign CTL_B_O    = state_q.ch[1].ctl;
  assign CLK_RX_B_O = state_q.rx_b;
  assign CLK_TX_B_O = state_q.tx_b;

endmodule : dccs_top

`default_nettype wire

// *** dccs_top_bench.sv ***
// testbench: command, status and clock select scenarios
`timescale 1ns/1ps
`default_nettype none

module dccs_top_bench
  import dccs_pkg::*;
;
  localparam dccs_rx_ev_t EV_CHAR = 7'h40, EV_BRK = 7'h60, EV_FEPE = 7'h58,
    EV_AD = 7'h44, EV_BEND = 7'h02, EV_RHR = 7'h01;
  localparam dccs_tx_ev_t EV_THR = 4'h8, EV_SHL = 4'h4, EV_STP = 4'h2,
    EV_TCK = 4'h1;

  logic         clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic         baud_set = 1'b0;
  logic [3:0]   addr = 4'h0;
  logic [7:0]   wdata = 8'h00, rdata;
  logic [1:0]   par_a = 2'h0, par_b = 2'h0;
  dccs_rx_ev_t  rx_a, rx_b;
  dccs_tx_ev_t  tx_a, tx_b;
  dccs_ctl_t    ctl_a, ctl_b;
  dccs_clksel_t csel_rx, csel_tx;
  int           fails = 0, n_checks = 0;

  always #10 clk = ~clk;

  dccs_top #(.FIFO_DEPTH(3)) i_dccs_top (
    .CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BAUD_SET_I(baud_set),
    .PAR_MODE_A_I(par_a), .PAR_MODE_B_I(par_b), .RX_EV_A_I(rx_a),
    .RX_EV_B_I(rx_b), .TX_EV_A_I(tx_a), .TX_EV_B_I(tx_b),
    .CTL_A_O(ctl_a), .CTL_B_O(ctl_b), .CLK_RX_B_O(csel_rx),
    .CLK_TX_B_O(csel_tx));
  dccs_partner i_dccs_partner_a (.clk_i(clk), .rx_ev_o(rx_a), .tx_ev_o(tx_a));
  dccs_partner i_dccs_partner_b (.clk_i(clk), .rx_ev_o(rx_b), .tx_ev_o(tx_b));

  // ------------
  // shared tasks
  // ------------
  task automatic stop_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp,
                        input logic [7:0] mask, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata & mask, exp, what);
  endtask : reg_rd

  task automatic cmd_a(input logic [7:0] d);
    reg_wr(OFS_CHA_CMD_STS, d);
  endtask : cmd_a

  task automatic sts_a(input logic [7:0] e, input logic [7:0] m,
                       input string what);
    reg_rd(OFS_CHA_CMD_STS, e, m, what);
  endtask : sts_a

  task automatic ra(input dccs_rx_ev_t e);
    i_dccs_partner_a.send(e, 4'h0, 0);
  endtask : ra

  task automatic ta(input dccs_tx_ev_t e);
    i_dccs_partner_a.send(7'h00, e, 4);
  endtask : ta

  // ------------
  // scenarios
  // ------------
  task automatic t_reset;
    chk(ctl_a, 8'h00, "ctl idle");
    sts_a(8'h00, 8'hff, "status at reset");
    reg_rd(OFS_IRQ_STATUS, 8'h00, 8'hff, "irq at reset");
    reg_rd(4'h9, 8'h00, 8'hff, "unmapped read");
  endtask : t_reset

  task automatic t_cmds;
    cmd_a(8'h05);
    chk(ctl_a, 8'hd0, "rx and tx enable");
    sts_a(8'h04, 8'h04, "ready on enable");
    cmd_a(8'h88);
    chk(ctl_a, 8'h80, "tx off, bit 7 ignored");
    sts_a(8'h00, 8'h0c, "ready and empty off");
    for (int i = 0; i < 6; i++) begin
      cmd_a({1'b0, i[2:0], 4'h0});
      chk(ctl_a & 8'h2c, (i == 1) ? 8'h04 : (i == 2) ? 8'h20 :
          (i == 3) ? 8'h08 : 8'h00, "misc pulse");
    end
    chk(ctl_a & 8'h80, 8'h00, "rx off after reset");
  endtask : t_cmds

  task automatic t_rx_fifo;
    cmd_a(8'h01);
    repeat (3) ra(EV_CHAR);
    sts_a(8'h03, 8'hf3, "fifo full");
    repeat (2) ra(EV_CHAR);
    sts_a(8'h13, 8'hf3, "overrun");
    ra(EV_RHR);
    sts_a(8'h13, 8'hf3, "full kept");
    repeat (2) ra(EV_RHR);
    sts_a(8'h11, 8'hf3, "full cleared");
    ra(EV_RHR);
    sts_a(8'h10, 8'hf3, "ready off");
    cmd_a(8'h40);
    sts_a(8'h00, 8'hf0, "errors reset");
  endtask : t_rx_fifo

  task automatic t_rx_err;
    ra(EV_BRK);
    sts_a(8'h81, 8'hf3, "break flag");
    reg_rd(OFS_IRQ_STATUS, 8'h04, 8'h44, "break change on start");
    cmd_a(8'h50);
    reg_rd(OFS_IRQ_STATUS, 8'h00, 8'h44, "break change cleared");
    ra(EV_BEND);
    reg_rd(OFS_IRQ_STATUS, 8'h04, 8'h44, "break change on end");
    cmd_a(8'h50);
    cmd_a(8'h20);
    sts_a(8'h80, 8'hf3, "rx reset keeps errors");
    cmd_a(8'h41);
    ra(EV_FEPE);
    sts_a(8'h61, 8'hf3, "framing and parity");
    cmd_a(8'h20);
    cmd_a(8'h41);
    @(posedge clk) par_a <= PAR_MULTIDROP;
    ra(EV_AD);
    sts_a(8'h21, 8'hf3, "address bit");
    cmd_a(8'h02);
    chk(ctl_a & 8'h80, 8'h80, "multidrop keeps receiving");
    @(posedge clk) par_a <= 2'h0;
    cmd_a(8'h02);
    chk(ctl_a & 8'h80, 8'h00, "receiver disabled");
  endtask : t_rx_err

  task automatic t_break;
    cmd_a(8'h30);
    cmd_a(8'h04);
    ta(EV_THR);
    cmd_a(8'h60);
    repeat (2) ta(EV_TCK);
    chk(ctl_a & 8'h03, 8'h00, "break waits for char");
    ta(EV_SHL);
    ta(EV_STP);
    repeat (2) ta(EV_TCK);
    chk(ctl_a & 8'h03, 8'h02, "break on line");
    cmd_a(8'h70);
    ta(EV_TCK);
    chk(ctl_a & 8'h03, 8'h01, "marking after break");
    ta(EV_TCK);
    chk(ctl_a & 8'h03, 8'h00, "marking bit over");
    cmd_a(8'h08);
    cmd_a(8'h60);
    repeat (3) ta(EV_TCK);
    chk(ctl_a & 8'h03, 8'h00, "break refused");
  endtask : t_break

  task automatic t_tx_flags;
    cmd_a(8'h04);
    sts_a(8'h04, 8'h04, "ready on enable");
    ta(EV_THR);
    sts_a(8'h00, 8'h0c, "holding loaded");
    ta(EV_SHL);
    sts_a(8'h04, 8'h0c, "moved to shifter");
    ta(EV_STP);
    sts_a(8'h0c, 8'h0c, "transmitter empty");
  endtask : t_tx_flags

  task automatic t_chan_b;
    dccs_src_t s;
    reg_wr(OFS_CHB_CMD_STS, 8'h05);
    chk(ctl_b, 8'hd0, "channel b enable");
    i_dccs_partner_b.send(EV_CHAR, 4'h0, 0);
    reg_rd(OFS_CHB_CMD_STS, 8'h05, 8'h07, "channel b status");
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clk) baud_set <= b[0];
        reg_wr(OFS_CHB_CLK_SEL, {c[3:0], c[3:0]});
        @(posedge clk);
        #1;
        s = (c == 13) ? SRC_TIMER : (c > 13) ? SRC_PIN : SRC_BRG;
        chk({csel_rx.src, csel_rx.is_1x, (c > 13) & csel_rx.pin_six},
            {s, c == 15, c == 15 || (c == 14 && b == 1)}, "rx clock");
        chk({csel_tx.src, csel_tx.is_1x, (c > 13) & csel_tx.pin_six},
            {s, c == 15, 1'b0}, "tx clock");
        if (c == 0) begin
          chk(csel_rx.brg_div, BRG_REF_HZ / (BRG_OVERSAMPLE *
              (b ? 75 : 50)), "rate divisor");
        end
        if (c > 12) begin
          chk(csel_tx.brg_div, 16'h0000, "no divisor off generator");
        end
      end
    end
  endtask : t_chan_b

  // ------------
  // main sequence and watchdog
  // ------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_cmds;
    t_rx_fifo;
    t_rx_err;
    t_break;
    t_tx_flags;
    t_chan_b;
    stop_test;
  end

  // the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    stop_test;
  end
endmodule : dccs_top_bench

`default_nettype wire

// *** dccs_top_monitor.sv ***
// checker: command decode and clock select relations at the top ports
`timescale 1ns/1ps
`default_nettype none

module dccs_top_monitor
  import dccs_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic              CLK_I,
  input wire logic              RSTN_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [7:0]        WDATA_I,
  input wire logic              WR_I,
  input wire logic [1:0]        PAR_MODE_A_I,
  input wire dccs_ctl_t         CTL_A_O,
  input wire dccs_ctl_t         CTL_B_O,
  input wire dccs_clksel_t      CLK_RX_B_O,
  input wire dccs_clksel_t      CLK_TX_B_O
);
  // ------------
  // write decode
  // ------------
  wire logic wr_a = WR_I && (ADDR_I == OFS_CHA_CMD_STS);
  wire logic wr_b = WR_I && (ADDR_I == OFS_CHB_CMD_STS);
  wire logic wr_c = WR_I && (ADDR_I == OFS_CHB_CLK_SEL);

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  a_ptr_reset_pulse:
  assert property (##1 CTL_A_O.mr_ptr_rst
    == $past(wr_a && WDATA_I[6:4] == 3'h1))
    else $error("pointer reset pulse mismatch");
  a_rx_enable_hunt:
  assert property (wr_a && WDATA_I[1:0] == 2'b01 && WDATA_I[6:4] != 3'h2
    && PAR_MODE_A_I != PAR_MULTIDROP |=> CTL_A_O.rx_active && CTL_A_O.rx_hunt)
    else $error("receiver enable without hunt");
  a_rx_disable_md:
  assert property (wr_a && WDATA_I[1:0] == 2'b10 && WDATA_I[6:4] != 3'h2
    |=> CTL_A_O.rx_active == $past(PAR_MODE_A_I == PAR_MULTIDROP))
    else $error("receiver disable wrong");
  a_rx_reset_flush:
  assert property (wr_a && WDATA_I[6:4] == 3'h2 |=> CTL_A_O.rx_flush)
    else $error("receiver reset without flush");
  a_tx_reset_pulse:
  assert property (wr_a && WDATA_I[6:4] == 3'h3 |=> CTL_A_O.tx_reset)
    else $error("transmitter reset missing");
  a_tx_enable_level:
  assert property (wr_a && WDATA_I[3:2] == 2'b01 && WDATA_I[6:4] != 3'h3
    |=> CTL_A_O.tx_en)
    else $error("transmitter enable lost");
  a_tx_disable_level:
  assert property (wr_a && WDATA_I[3] |=> !CTL_A_O.tx_en)
    else $error("transmitter disable lost");
  a_chan_b_mirror:
  assert property (wr_b && WDATA_I[3:2] == 2'b01 && WDATA_I[6:4] != 3'h3
    |=> CTL_B_O.tx_en && $stable(CTL_A_O.tx_en))
    else $error("channel b command misrouted");
  a_break_gate_off:
  assert property (wr_a && WDATA_I[6:4] == 3'h6 && !CTL_A_O.tx_en
    && !CTL_A_O.break_out |=> !CTL_A_O.break_out [*8])
    else $error("break started while disabled");
  a_break_end_mark:
  assert property ($fell(CTL_A_O.break_out) |-> CTL_A_O.mark_hold)
    else $error("no marking bit after break");
  a_tx_pin_16x:
  assert property (wr_c && WDATA_I[3:0] == CSEL_PIN16 |-> ##2
    CLK_TX_B_O.src == SRC_PIN && !CLK_TX_B_O.is_1x && !CLK_TX_B_O.pin_six)
    else $error("tx pin clock wrong");
  a_rx_pin_1x:
  assert property (wr_c && WDATA_I[7:4] == CSEL_PIN1 |-> ##2
    CLK_RX_B_O.src == SRC_PIN && CLK_RX_B_O.is_1x && CLK_RX_B_O.pin_six)
    else $error("rx 1x pin clock wrong");
  a_rx_other_16x:
  assert property (wr_c && WDATA_I[7:4] != CSEL_PIN1
    |-> ##2 !CLK_RX_B_O.is_1x)
    else $error("rx clock not 16x");
endmodule : dccs_top_monitor

bind dccs_top dccs_top_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_dccs_top_monitor (
  .CLK_I        (CLK_I),
  .RSTN_I       (RSTN_I),
  .ADDR_I       (ADDR_I),
  .WDATA_I      (WDATA_I),
  .WR_I         (WR_I),
  .PAR_MODE_A_I (PAR_MODE_A_I),
  .CTL_A_O      (CTL_A_O),
  .CTL_B_O      (CTL_B_O),
  .CLK_RX_B_O   (CLK_RX_B_O),
  .CLK_TX_B_O   (CLK_TX_B_O)
);

`default_nettype wire
